// file: hdl/rtwc_timer.sv
// reload timer with capture: 16-bit or split 8-bit counter, register port
// assumes all inputs are synchronous to mclk except extClk and cmpOut
`timescale 1ns/100ps

`include "rtwc_defines.svh"

module rtwc_timer
  import rtwc_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    sys_rst,
  input  wire logic [`RTWC_ADDR_W-1:0] regAddr,
  input  wire logic [7:0]              regWdata,
  input  wire logic                    regWr,
  input  wire logic                    regRd,
  output logic      [7:0]              regRdata,
  input  wire logic                    timerIrqEn,
  input  wire logic                    extClk,
  input  wire logic                    cmpOut,
  output logic                         timerIrq,
  output logic                         evtIrq
);

  // tick for one byte: system clock when its select bit is set
  function automatic logic selTick
  (
    input logic      byteSel,
    input rtwc_alt_t alt,
    input logic      tick12,
    input logic      tickExt,
    input logic      tickCmp
  );
    logic t;
    t = 1'b0;
    if (byteSel)
    begin
      t = 1'b1;
    end
    else
    begin
      case (alt)
        RTWC_ALT_SYS12:  t = tick12;
        RTWC_ALT_EXT8:   t = tickExt;
        RTWC_ALT_SYS12B: t = tick12;
        RTWC_ALT_CMP:    t = tickCmp;
        default:         t = 1'b0;
      endcase
    end
    return t;
  endfunction

  function automatic logic isWr
  (
    input logic                    wr,
    input logic [`RTWC_ADDR_W-1:0] addr,
    input logic [`RTWC_ADDR_W-1:0] ofs
  );
    return wr && (addr == ofs);
  endfunction

  logic [7:0]             ctrlReg;
  logic [7:0]             ctrlNext;
  logic [7:0]             rldLoReg;
  logic [7:0]             rldHiReg;
  logic [7:0]             cntLoReg;
  logic [7:0]             cntHiReg;
  logic [7:0]             cntLoNext;
  logic [7:0]             cntHiNext;
  logic [1:0]             clkSelReg;
  logic [3:0]             div12Reg;
  logic                   tick12;
  logic                   extSync1;
  logic                   extSync2;
  logic                   extPrev;
  logic [2:0]             extCntReg;
  logic                   tickExt;
  logic                   cmpSync1;
  logic                   cmpSync2;
  logic                   cmpPrev;
  logic                   tickCmp;
  logic                   tickLo;
  logic                   tickHi;
  logic                   wrapLo;
  logic                   wrapHi;
  logic                   capEvt;
  logic [`RTWC_EVT_W-1:0] evtStatReg;
  logic [`RTWC_EVT_W-1:0] evtEnReg;
  logic [`RTWC_EVT_W-1:0] evtSet;
  logic [`RTWC_EVT_W-1:0] evtStatNext;
  rtwc_alt_t              altSel;
  logic                   splitMode;
  logic                   runHi;
  logic                   capMode;
  logic                   wrCtrl;

  assign altSel    = rtwc_alt_t'(ctrlReg[`RTWC_CTRL_ALT_MSB:`RTWC_CTRL_ALT_LSB]);
  assign splitMode = ctrlReg[`RTWC_CTRL_SPLIT];
  assign runHi     = ctrlReg[`RTWC_CTRL_RUN];
  assign capMode   = ctrlReg[`RTWC_CTRL_CAP_EN];
  assign wrCtrl    = isWr(regWr, regAddr, `RTWC_OFS_CTRL);

  // system clock divided by twelve, one-cycle enable
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      div12Reg <= `RTWC_DIV12_RST;
    end
    else if (div12Reg == `RTWC_DIV12_LAST)
    begin
      div12Reg <= `RTWC_DIV12_RST;
    end
    else
    begin
      div12Reg <= div12Reg + 4'h1;
    end
  end

  assign tick12 = (div12Reg == `RTWC_DIV12_LAST);

  // external oscillator: two-stage synchronizer, then edge count of eight
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      extSync1 <= 1'b0;
      extSync2 <= 1'b0;
      extPrev  <= 1'b0;
    end
    else
    begin
      extSync1 <= extClk;
      extSync2 <= extSync1;
      extPrev  <= extSync2;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      extCntReg <= `RTWC_EXT_DIV_RST;
    end
    else if (extSync2 && !extPrev)
    begin
      extCntReg <= extCntReg + 3'h1;
    end
  end

  assign tickExt = extSync2 && !extPrev && (extCntReg == `RTWC_EXT_DIV_LAST);

  // comparator: two-stage synchronizer, rising edge
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      cmpSync1 <= 1'b0;
      cmpSync2 <= 1'b0;
      cmpPrev  <= 1'b0;
    end
    else
    begin
      cmpSync1 <= cmpOut;
      cmpSync2 <= cmpSync1;
      cmpPrev  <= cmpSync2;
    end
  end

  assign tickCmp = cmpSync2 && !cmpPrev;

  assign tickHi = selTick(clkSelReg[`RTWC_CLKSEL_HI], altSel, tick12, tickExt, tickCmp);
  assign tickLo = selTick(clkSelReg[`RTWC_CLKSEL_LO], altSel, tick12, tickExt, tickCmp);

  // capture trigger picked by the upper alternate select bit
  assign capEvt = capMode &&
                  (altSel[1] ? tickExt : tickCmp);

  // counter next state
  always_comb
  begin
    cntLoNext = cntLoReg;
    cntHiNext = cntHiReg;
    wrapLo    = 1'b0;
    wrapHi    = 1'b0;
    if (splitMode)
    begin
      if (tickLo)
      begin
        wrapLo    = (cntLoReg == `RTWC_BYTE_MAX);
        cntLoNext = wrapLo ? rldLoReg : cntLoReg + 8'h01;
      end
      if (tickHi && runHi)
      begin
        wrapHi    = (cntHiReg == `RTWC_BYTE_MAX);
        cntHiNext = wrapHi ? rldHiReg : cntHiReg + 8'h01;
      end
    end
    else if (runHi && tickLo)
    begin
      wrapLo = (cntLoReg == `RTWC_BYTE_MAX);
      wrapHi = wrapLo && (cntHiReg == `RTWC_BYTE_MAX);
      if (wrapHi && !capMode)
      begin
        cntLoNext = rldLoReg;
        cntHiNext = rldHiReg;
      end
      else
      begin
        cntLoNext = cntLoReg + 8'h01;
        cntHiNext = cntHiReg + {7'h00, wrapLo};
      end
    end
    if (isWr(regWr, regAddr, `RTWC_OFS_CNT_LO))
    begin
      cntLoNext = regWdata;
    end
    if (isWr(regWr, regAddr, `RTWC_OFS_CNT_HI))
    begin
      cntHiNext = regWdata;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      cntLoReg <= `RTWC_BYTE_RST;
      cntHiReg <= `RTWC_BYTE_RST;
    end
    else
    begin
      cntLoReg <= cntLoNext;
      cntHiReg <= cntHiNext;
    end
  end

  // reload pair: capture takes priority over a software write
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rldLoReg <= `RTWC_BYTE_RST;
      rldHiReg <= `RTWC_BYTE_RST;
    end
    else if (capEvt)
    begin
      rldLoReg <= cntLoReg;
      rldHiReg <= cntHiReg;
    end
    else
    begin
      if (isWr(regWr, regAddr, `RTWC_OFS_RLD_LO))
      begin
        rldLoReg <= regWdata;
      end
      if (isWr(regWr, regAddr, `RTWC_OFS_RLD_HI))
      begin
        rldHiReg <= regWdata;
      end
    end
  end

  // control byte: flags set by hardware or by a write, hardware set wins over a write
  always_comb
  begin
    ctrlNext = wrCtrl ? regWdata : ctrlReg;
    if (wrapHi || capEvt)
    begin
      ctrlNext[`RTWC_CTRL_OVF_HI] = 1'b1;
    end
    if (wrapLo)
    begin
      ctrlNext[`RTWC_CTRL_OVF_LO] = 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ctrlReg <= `RTWC_BYTE_RST;
    end
    else
    begin
      ctrlReg <= ctrlNext;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      clkSelReg <= `RTWC_CLKSEL_RST;
    end
    else if (isWr(regWr, regAddr, `RTWC_OFS_CLKSEL))
    begin
      clkSelReg <= regWdata[1:0];
    end
  end

  // timer request follows the high flag, and the low flag only with RTWC_CTRL_LO_IRQ set, while the external enable is high
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      timerIrq <= 1'b0;
    end
    else
    begin
      timerIrq <= timerIrqEn &&
                  (ctrlReg[`RTWC_CTRL_OVF_HI] ||
                   (ctrlReg[`RTWC_CTRL_LO_IRQ] &&
                    ctrlReg[`RTWC_CTRL_OVF_LO]));
    end
  end

  // sticky event status, write-one clear, set wins
  always_comb
  begin
    evtSet                   = `RTWC_EVT_RST;
    evtSet[`RTWC_EVT_OVF_HI] = wrapHi;
    evtSet[`RTWC_EVT_OVF_LO] = wrapLo;
    evtSet[`RTWC_EVT_CAP]    = capEvt;
    evtStatNext              = evtStatReg;
    if (isWr(regWr, regAddr, `RTWC_OFS_EVT_CLR))
    begin
      evtStatNext = evtStatReg & ~regWdata[`RTWC_EVT_W-1:0];
    end
    evtStatNext = evtStatNext | evtSet;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      evtStatReg <= `RTWC_EVT_RST;
    end
    else
    begin
      evtStatReg <= evtStatNext;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      evtEnReg <= `RTWC_EVT_RST;
    end
    else if (isWr(regWr, regAddr, `RTWC_OFS_EVT_EN))
    begin
      evtEnReg <= regWdata[`RTWC_EVT_W-1:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      evtIrq <= 1'b0;
    end
    else
    begin
      evtIrq <= |(evtStatNext & evtEnReg);
    end
  end

  // read data valid only in the cycle after the read strobe
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      regRdata <= `RTWC_BYTE_RST;
    end
    else if (regRd)
    begin
      case (regAddr)
        `RTWC_OFS_CTRL:     regRdata <= ctrlReg;
        `RTWC_OFS_RLD_LO:   regRdata <= rldLoReg;
        `RTWC_OFS_RLD_HI:   regRdata <= rldHiReg;
        `RTWC_OFS_CNT_LO:   regRdata <= cntLoReg;
        `RTWC_OFS_CNT_HI:   regRdata <= cntHiReg;
        `RTWC_OFS_CLKSEL:   regRdata <= {6'h00, clkSelReg};
        `RTWC_OFS_EVT_STAT: regRdata <= {5'h00, evtStatReg};
        `RTWC_OFS_EVT_EN:   regRdata <= {5'h00, evtEnReg};
        default:            regRdata <= `RTWC_BYTE_RST;
      endcase
    end
    else
    begin
      regRdata <= `RTWC_BYTE_RST;
    end
  end

endmodule // rtwc_timer

// file: hdl/rtwc_defines.svh
// register offsets, field positions, reset values and counts for the timer
// assumes a byte-wide register port with a four-bit address
`ifndef RTWC_DEFINES_SVH
`define RTWC_DEFINES_SVH

`define RTWC_ADDR_W        4
`define RTWC_OFS_CTRL      4'h0
`define RTWC_OFS_RLD_LO    4'h1
`define RTWC_OFS_RLD_HI    4'h2
`define RTWC_OFS_CNT_LO    4'h3
`define RTWC_OFS_CNT_HI    4'h4
`define RTWC_OFS_CLKSEL    4'h5
`define RTWC_OFS_EVT_STAT  4'h6
`define RTWC_OFS_EVT_CLR   4'h7
`define RTWC_OFS_EVT_EN    4'h8

`define RTWC_CTRL_OVF_HI   7
`define RTWC_CTRL_OVF_LO   6
`define RTWC_CTRL_LO_IRQ   5
`define RTWC_CTRL_CAP_EN   4
`define RTWC_CTRL_SPLIT    3
`define RTWC_CTRL_RUN      2
`define RTWC_CTRL_ALT_MSB  1
`define RTWC_CTRL_ALT_LSB  0

`define RTWC_CLKSEL_LO     0
`define RTWC_CLKSEL_HI     1

`define RTWC_EVT_W         3
`define RTWC_EVT_OVF_HI    0
`define RTWC_EVT_OVF_LO    1
`define RTWC_EVT_CAP       2
`define RTWC_EVT_RST       3'h0

`define RTWC_BYTE_RST      8'h00
`define RTWC_BYTE_MAX      8'hFF
`define RTWC_CLKSEL_RST    2'h0
`define RTWC_DIV12_LAST    4'hB
`define RTWC_DIV12_RST     4'h0
`define RTWC_EXT_DIV_LAST  3'h7
`define RTWC_EXT_DIV_RST   3'h0

`endif

// file: hdl/rtwc_pkg.sv
// types shared by the reload timer
// assumes the defines header supplies offsets and field positions
package rtwc_pkg;

  // alternate clock select encoding, in field order
  typedef enum logic [1:0]
  {
    RTWC_ALT_SYS12,
    RTWC_ALT_EXT8,
    RTWC_ALT_SYS12B,
    RTWC_ALT_CMP
  } rtwc_alt_t;

endpackage

// file: sim/rtwc_src_model.sv
// far-side sources: external oscillator and comparator output
// assumes free-running sources, each level longer than 2 mclk
`timescale 1ns/100ps
module rtwc_src_model
(
  output logic extClk,
  output logic cmpOut
);
  initial
  begin
    extClk = 1'b0;
    cmpOut = 1'b0;
  end
  // 40 ns period, so divide-by-8 gives one tick per 40 mclk
  always #20 extClk = ~extClk;
  // 128 ns period, one rising edge per 16 mclk
  always #64 cmpOut = ~cmpOut;
endmodule // rtwc_src_model

// file: sim/rtwc_timer_properties.sv
// port checker for the reload timer
// assumes it is bound to rtwc_timer, one clock domain
`timescale 1ns/100ps
module rtwc_timer_chk
(
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdata,
  input wire logic       timerIrqEn,
  input wire logic       timerIrq,
  input wire logic       evtIrq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_rd_idle_zero: assert property (!regRd |=> regRdata == 8'h00)
    else $error("read data not zero outside a read");
  a_rd_unmapped: assert property (regRd && (regAddr == 4'h7 || regAddr > 4'h8)
    |=> regRdata == 8'h00) else $error("unmapped read not zero");
  a_ctrl_wr_back: assert property (regWr && regAddr == 4'h0 ##1 regRd && regAddr == 4'h0
    |=> regRdata[5:0] == $past(regWdata[5:0], 2)) else $error("control bits lost");
  a_count_wr_back: assert property (regWr && regAddr == 4'h3 ##1 regRd && regAddr == 4'h3
    |=> regRdata == $past(regWdata, 2)) else $error("count write lost");
  a_clksel_wr_back: assert property (regWr && regAddr == 4'h5 ##1 regRd && regAddr == 4'h5
    |=> regRdata[1:0] == $past(regWdata[1:0], 2)) else $error("clock select lost");
  a_irq_gate: assert property (!timerIrqEn |=> !timerIrq)
    else $error("interrupt while disabled");
  a_flag_irq: assert property (regWr && regAddr == 4'h0 && regWdata[7] ##1 timerIrqEn
    |=> timerIrq) else $error("set flag gave no interrupt");
  a_irq_sticky: assert property (timerIrq && timerIrqEn && !$past(regWr) |=> timerIrq)
    else $error("interrupt dropped without software");
  a_irq_cause: assert property (regRd && regAddr == 4'h0 && timerIrq && !$past(regWr)
    |=> regRdata[7:6] != 2'b00) else $error("interrupt without flag");
  a_evt_sticky: assert property (evtIrq && !regWr && !$past(regWr) |=> evtIrq)
    else $error("event interrupt dropped");

  c_timer_irq: cover property ($rose(timerIrq));
  c_evt_irq: cover property ($rose(evtIrq));
  c_reload_rd: cover property (regRd && regAddr == 4'h1);
endmodule // rtwc_timer_chk

bind rtwc_timer rtwc_timer_chk i_chk (.mclk(mclk), .sys_rst(sys_rst),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata(regRdata), .timerIrqEn(timerIrqEn), .timerIrq(timerIrq),
  .evtIrq(evtIrq));

// file: sim/rtwc_timer_tb.sv
// self-checking bench for the reload timer
// assumes the source model drives extClk and cmpOut
`timescale 1ns/100ps
`include "rtwc_defines.svh"
module rtwc_timer_tb;
  logic       mclk       = 1'b0;
  logic       sys_rst    = 1'b1;
  logic [3:0] regAddr    = 4'h0;
  logic [7:0] regWdata   = 8'h00;
  logic       regWr      = 1'b0;
  logic       regRd      = 1'b0;
  logic       timerIrqEn = 1'b0;
  logic [7:0] regRdata;
  logic       extClk;
  logic       cmpOut;
  logic       timerIrq;
  logic       evtIrq;
  logic [7:0] v;
  logic [7:0] w;
  int         mismatches = 0;
  int         compares   = 0;

  always #4 mclk = ~mclk;

  rtwc_timer i_dut (.mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .timerIrqEn(timerIrqEn), .extClk(extClk), .cmpOut(cmpOut),
    .timerIrq(timerIrq), .evtIrq(evtIrq));
  rtwc_src_model i_src (.extClk(extClk), .cmpOut(cmpOut));

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk) {regWr, regRd} <= 2'b00;
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    {regWr, regRd} <= 2'b10;
    regAddr <= a;
    regWdata <= d;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    {regWr, regRd} <= 2'b01;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask

  task automatic wait_irq(input bit evt, input int lim);
    int i;
    for (i = 0; i < lim && (evt ? evtIrq : timerIrq) !== 1'b1; i++)
      idle(1);
    if (i == lim)
    begin
      chk(8'h00, 8'h01);
      report_and_stop();
    end
  endtask

  task automatic s_reset();
    for (int a = 0; a < 16; a++)
    begin
      rd(a[3:0]);
      chk(v, 8'h00);
    end
  endtask

  task automatic s_wrap16();
    @(posedge mclk) timerIrqEn <= 1'b1;
    wr(`RTWC_OFS_CLKSEL, 8'h01);
    rd(`RTWC_OFS_CLKSEL);
    chk(v, 8'h01);
    wr(`RTWC_OFS_RLD_LO, 8'h34);
    wr(`RTWC_OFS_RLD_HI, 8'h12);
    wr(`RTWC_OFS_CNT_HI, 8'hFF);
    wr(`RTWC_OFS_CNT_LO, 8'hF0);
    rd(`RTWC_OFS_CNT_LO);
    chk(v, 8'hF0);
    wr(`RTWC_OFS_CTRL, 8'h04);
    wait_irq(0, 40);
    rd(`RTWC_OFS_CTRL);
    chk(v, 8'hC4);
    wr(`RTWC_OFS_CTRL, 8'h80);
    rd(`RTWC_OFS_CTRL);
    chk(v, 8'h80);
    rd(`RTWC_OFS_CNT_HI);
    chk(v, 8'h12);
    chk({7'h0, timerIrq}, 8'h01);
    @(posedge mclk) timerIrqEn <= 1'b0;
    idle(2);
    chk({7'h0, timerIrq}, 8'h00);
    @(posedge mclk) timerIrqEn <= 1'b1;
    wr(`RTWC_OFS_CTRL, 8'h00);
  endtask

  task automatic s_lo16();
    wr(`RTWC_OFS_CNT_LO, 8'hF0);
    wr(`RTWC_OFS_CTRL, 8'h04);
    idle(30);
    chk({7'h0, timerIrq}, 8'h00);
    rd(`RTWC_OFS_CTRL);
    chk(v, 8'h44);
    wr(`RTWC_OFS_CTRL, 8'h64);
    idle(2);
    chk({7'h0, timerIrq}, 8'h01);
    wr(`RTWC_OFS_CTRL, 8'h00);
  endtask

  task automatic s_split();
    wr(`RTWC_OFS_CLKSEL, 8'h03);
    wr(`RTWC_OFS_RLD_LO, 8'hA0);
    wr(`RTWC_OFS_RLD_HI, 8'hB0);
    wr(`RTWC_OFS_CNT_HI, 8'hFE);
    wr(`RTWC_OFS_CNT_LO, 8'hF8);
    wr(`RTWC_OFS_CTRL, 8'h08);
    idle(20);
    rd(`RTWC_OFS_CNT_HI);
    chk(v, 8'hFE);
    rd(`RTWC_OFS_CTRL);
    chk(v, 8'h48);
    chk({7'h0, timerIrq}, 8'h00);
    rd(`RTWC_OFS_CNT_LO);
    chk({7'h0, v >= 8'hA0 && v < 8'hC0}, 8'h01);
    wr(`RTWC_OFS_CTRL, 8'h4C);
    idle(4);
    chk({7'h0, timerIrq}, 8'h01);
    rd(`RTWC_OFS_CTRL);
    chk(v, 8'hCC);
    rd(`RTWC_OFS_CNT_HI);
    chk({7'h0, v >= 8'hB0 && v < 8'hB9}, 8'h01);
    wr(`RTWC_OFS_CTRL, 8'h00);
  endtask

  task automatic s_clocks();
    logic [7:0] exp [4];
    // ticks expected in about 242 cycles: /12, ext/8, /12, comparator
    exp = '{8'd20, 8'd6, 8'd20, 8'd15};
    wr(`RTWC_OFS_CLKSEL, 8'h02);
    for (int k = 0; k < 4; k++)
    begin
      wr(`RTWC_OFS_CTRL, 8'h08 | k[7:0]);
      wr(`RTWC_OFS_CNT_LO, 8'h00);
      idle(240);
      rd(`RTWC_OFS_CNT_LO);
      chk({7'h0, v + 8'h01 - exp[k] <= 8'h02}, 8'h01);
    end
  endtask

  task automatic s_capture();
    wr(`RTWC_OFS_CLKSEL, 8'h01);
    wr(`RTWC_OFS_EVT_EN, 8'h04);
    wr(`RTWC_OFS_CTRL, 8'h14);
    wait_irq(1, 60);
    rd(`RTWC_OFS_RLD_LO);
    w = v;
    idle(16);
    rd(`RTWC_OFS_RLD_LO);
    chk(v - w, 8'h10);
    rd(`RTWC_OFS_CTRL);
    chk(v & 8'h80, 8'h80);
    chk({7'h0, timerIrq}, 8'h01);
    wr(`RTWC_OFS_EVT_EN, 8'h00);
    idle(2);
    chk({7'h0, evtIrq}, 8'h00);
    wr(`RTWC_OFS_CTRL, 8'h16);
    wr(`RTWC_OFS_EVT_CLR, 8'h07);
    idle(90);
    rd(`RTWC_OFS_EVT_STAT);
    chk(v & 8'h04, 8'h04);
    wr(`RTWC_OFS_CTRL, 8'h00);
    wr(`RTWC_OFS_EVT_CLR, 8'h07);
    rd(`RTWC_OFS_EVT_STAT);
    chk(v, 8'h00);
  endtask

  initial
  begin
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    s_reset();
    s_wrap16();
    s_lo16();
    s_split();
    s_clocks();
    s_capture();
    report_and_stop();
  end
endmodule // rtwc_timer_tb
